// ==== shared/mpors_pkg.sv ====
// Shared constants and types for the power-on and restart sequencer ends
// Behaviour
// - Start on switch-on rising edge
// - Host waits 100 ms after supply
// - Microsecond switch-on pulse suffices
// - Host lowers switch-on after start
// - Restart low over 10 ms resets
// - Restart on restart line release
// - Restart continues like normal start
// - Host restarts after 5 s silence
// - Reset state, then firmware init
// - Ready lines low mark init done
// - Reset pad configuration applied
// - Lines become inputs, pull-downs kept
// - Functionality command restarts
// - Switch-off command shuts down cleanly
// - Power-down keeps only real-time clock
// - Host silent after switch-off
// - Supply kept until rail low
// - Host never drives unpowered pads
// - Start notice; host waits for it
package mpors_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
   localparam int SUPPLY_TO_ON_MS = 100;
   localparam int SUPPLY_TO_ON_CYC = SUPPLY_TO_ON_MS * CYC_PER_MS;
   localparam int ON_PULSE_US = 1;
   localparam int ON_PULSE_CYC = (ON_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EMERG_LOW_MS = 10;
   localparam int EMERG_LOW_CYC = EMERG_LOW_MS * CYC_PER_MS;
   // Host margin over device threshold
   localparam int EMERG_HOLD_MS = 11;
   localparam int EMERG_HOLD_CYC = EMERG_HOLD_MS * CYC_PER_MS;
   localparam int NO_RESPONSE_S = 5;
   localparam int NO_RESPONSE_CYC = NO_RESPONSE_S * 1000 * CYC_PER_MS;
   localparam int RESET_DWELL_CYC = 8;
   localparam int INIT_CYC_DEF = 1000;
   localparam int SHUTDOWN_CYC_DEF = 1000;
   localparam int CNT_W = 32;

   // ------------------------------------------------------------
   // Command channel
   // ------------------------------------------------------------
   localparam int CMD_W = 2;
   localparam logic [CMD_W-1:0] CMD_NONE = 2'h0;
   localparam logic [CMD_W-1:0] CMD_SWITCH_OFF = 2'h1;
   localparam logic [CMD_W-1:0] CMD_FUNC_RESET = 2'h2;

   // ------------------------------------------------------------
   // Pad configuration codes
   // ------------------------------------------------------------
   localparam int PAD_W = 2;
   localparam logic [PAD_W-1:0] PAD_OFF = 2'h0;
   localparam logic [PAD_W-1:0] PAD_RESET = 2'h1;
   localparam logic [PAD_W-1:0] PAD_FIRMWARE = 2'h2;

   // ------------------------------------------------------------
   // State machines
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      DEV_OFF = 8'h01,
      DEV_IDLE = 8'h02,
      DEV_RESET = 8'h04,
      DEV_INIT = 8'h08,
      DEV_RUN = 8'h10,
      DEV_SHUTDN = 8'h20,
      DEV_PDOWN = 8'h40,
      DEV_HELD = 8'h80
   } mpors_dev_state_t;

   typedef enum logic [6:0] {
      HST_OFF = 7'h01,
      HST_SETTLE = 7'h02,
      HST_PULSE = 7'h04,
      HST_WAIT_START = 7'h08,
      HST_READY = 7'h10,
      HST_EMERG = 7'h20,
      HST_WAIT_RAIL = 7'h40
   } mpors_host_state_t;

endpackage : mpors_pkg

// ==== shared/mpors_if.sv ====
// Pin level link between the host controller and the modem module
`timescale 1ns/100ps
interface mpors_if;
   logic mainSupply, switchOn, restartOut, restartOe, emergencyRestartN, coreRailIndicator;
   logic portAClearToSend, portASetReady, portARingIndicator, portBClearToSend, cmdValid;
   logic [mpors_pkg::CMD_W-1:0] cmdCode;
   logic systemStartNotice;

   // Open-drain restart line with pull-up
   assign emergencyRestartN = restartOe ? restartOut : 1'b1;

   modport dev (
      input mainSupply, switchOn, emergencyRestartN, cmdValid, cmdCode,
      output coreRailIndicator, portAClearToSend, portASetReady, portARingIndicator,
      portBClearToSend, systemStartNotice
   );

   modport host (
      output mainSupply, switchOn, restartOut, restartOe, cmdValid, cmdCode,
      input coreRailIndicator, portAClearToSend, portASetReady, portARingIndicator,
      portBClearToSend, systemStartNotice
   );
endinterface : mpors_if

// ==== rtl/mpors_device.sv ====
// Module end: start, emergency restart and shutdown sequencing of the pads
`timescale 1ns/100ps
module mpors_device #(
   parameter int EMERG_LOW_CYC = mpors_pkg::EMERG_LOW_CYC,
   parameter int INIT_CYC = mpors_pkg::INIT_CYC_DEF,
   parameter int SHUTDOWN_CYC = mpors_pkg::SHUTDOWN_CYC_DEF
) (
   input wire logic clock,
   input wire logic arst_n,
   mpors_if.dev link,
   output mpors_pkg::mpors_dev_state_t deviceState,
   output logic [mpors_pkg::PAD_W-1:0] padMode,
   output logic gpioPullDown,
   output logic gpioInput,
   output logic rtcActive
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic swMeta_r, swSync_r, swPrev_r, rstMeta_r, rstSync_r, rstPrev_r, swRise, rstRise;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         swMeta_r <= 1'b0;
         swSync_r <= 1'b0;
         swPrev_r <= 1'b0;
         rstMeta_r <= 1'b1;
         rstSync_r <= 1'b1;
         rstPrev_r <= 1'b1;
      end else begin
         swMeta_r <= link.switchOn;
         swSync_r <= swMeta_r;
         swPrev_r <= swSync_r;
         rstMeta_r <= link.emergencyRestartN;
         rstSync_r <= rstMeta_r;
         rstPrev_r <= rstSync_r;
      end
   end

   // edge sensitive, one sampled high suffices
   assign swRise = swSync_r & ~swPrev_r;
   assign rstRise = rstSync_r & ~rstPrev_r;

   // ------------------------------------------------------------
   // Restart low-time measurement
   // ------------------------------------------------------------
   logic [mpors_pkg::CNT_W-1:0] lowCnt_r, lowCnt_nxt;
   logic lowLong;

   always_comb begin
      lowCnt_nxt = lowCnt_r;
      if (rstSync_r) begin
         lowCnt_nxt = '0;
      end else if (lowCnt_r <= mpors_pkg::CNT_W'(EMERG_LOW_CYC)) begin
         lowCnt_nxt = lowCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt_r <= '0;
      end else begin
         lowCnt_r <= lowCnt_nxt;
      end
   end

   assign lowLong = (lowCnt_r > mpors_pkg::CNT_W'(EMERG_LOW_CYC));

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   mpors_pkg::mpors_dev_state_t state_r;
   mpors_pkg::mpors_dev_state_t state_nxt;
   logic [mpors_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic noticeNxt, cmdOff, cmdFunc;

   assign cmdOff = link.cmdValid && (link.cmdCode == mpors_pkg::CMD_SWITCH_OFF);
   assign cmdFunc = link.cmdValid && (link.cmdCode == mpors_pkg::CMD_FUNC_RESET);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 1'b1;
      noticeNxt = 1'b0;
      if (!link.mainSupply) begin
         state_nxt = mpors_pkg::DEV_OFF;
         cnt_nxt = '0;
      end else if (lowLong && state_r != mpors_pkg::DEV_HELD) begin
         // processor and pads forced to reset
         state_nxt = mpors_pkg::DEV_HELD;
         cnt_nxt = '0;
      end else begin
         case (state_r)
            mpors_pkg::DEV_OFF: begin
               state_nxt = mpors_pkg::DEV_IDLE;
               cnt_nxt = '0;
            end
            mpors_pkg::DEV_IDLE, mpors_pkg::DEV_PDOWN: begin
               cnt_nxt = '0;
               if (swRise) begin
                  state_nxt = mpors_pkg::DEV_RESET;
               end
            end
            mpors_pkg::DEV_HELD: begin
               cnt_nxt = '0;
               if (rstRise) begin
                  state_nxt = mpors_pkg::DEV_RESET;
               end
            end
            mpors_pkg::DEV_RESET: begin
               if (cnt_r >= mpors_pkg::CNT_W'(mpors_pkg::RESET_DWELL_CYC - 1)) begin
                  state_nxt = mpors_pkg::DEV_INIT;
                  cnt_nxt = '0;
               end
            end
            mpors_pkg::DEV_INIT: begin
               if (cnt_r >= mpors_pkg::CNT_W'(INIT_CYC - 1)) begin
                  state_nxt = mpors_pkg::DEV_RUN;
                  cnt_nxt = '0;
                  noticeNxt = 1'b1;
               end
            end
            mpors_pkg::DEV_RUN: begin
               cnt_nxt = '0;
               if (cmdOff) begin
                  // log off and save before power-down
                  state_nxt = mpors_pkg::DEV_SHUTDN;
               end else if (cmdFunc) begin
                  state_nxt = mpors_pkg::DEV_RESET;
               end
            end
            mpors_pkg::DEV_SHUTDN: begin
               if (cnt_r >= mpors_pkg::CNT_W'(SHUTDOWN_CYC - 1)) begin
                  state_nxt = mpors_pkg::DEV_PDOWN;
                  cnt_nxt = '0;
               end
            end
            default: begin
               state_nxt = mpors_pkg::DEV_OFF;
               cnt_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= mpors_pkg::DEV_OFF;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pad and indicator outputs
   // ------------------------------------------------------------
   function automatic logic [mpors_pkg::PAD_W-1:0] padOf(input mpors_pkg::mpors_dev_state_t s);
      case (s)
         mpors_pkg::DEV_RESET, mpors_pkg::DEV_HELD: padOf = mpors_pkg::PAD_RESET;
         mpors_pkg::DEV_INIT, mpors_pkg::DEV_RUN, mpors_pkg::DEV_SHUTDN: begin
            padOf = mpors_pkg::PAD_FIRMWARE;
         end
         default: padOf = mpors_pkg::PAD_OFF;
      endcase
   endfunction : padOf

   logic [mpors_pkg::PAD_W-1:0] padNxt;
   logic railNxt, readyNxt, pullUpNxt, railOut_r, readyLow_r, notice_r;

   always_comb begin
      padNxt = padOf(state_nxt);
      // same pad path after any restart; rail off in power-down
      railNxt = (padNxt != mpors_pkg::PAD_OFF);
      readyNxt = (state_nxt == mpors_pkg::DEV_RUN);
      // handshake lines pulled up while in reset, initialising or shutting down
      pullUpNxt = railNxt && !readyNxt;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         padMode <= mpors_pkg::PAD_OFF;
         gpioPullDown <= 1'b0;
         gpioInput <= 1'b0;
         rtcActive <= 1'b0;
         deviceState <= mpors_pkg::DEV_OFF;
         railOut_r <= 1'b0;
         readyLow_r <= 1'b0;
         notice_r <= 1'b0;
      end else begin
         padMode <= padNxt;
         // pull-downs kept, lines become inputs from the start of init
         gpioPullDown <= (padNxt != mpors_pkg::PAD_OFF);
         gpioInput <= (padNxt == mpors_pkg::PAD_FIRMWARE);
         // only the clock keeps running in power-down
         rtcActive <= link.mainSupply;
         deviceState <= state_nxt;
         railOut_r <= railNxt;
         readyLow_r <= pullUpNxt;
         notice_r <= noticeNxt;
      end
   end

   assign link.coreRailIndicator = railOut_r;
   assign link.portAClearToSend = readyLow_r;
   assign link.portASetReady = readyLow_r;
   assign link.portARingIndicator = readyLow_r;
   assign link.portBClearToSend = readyLow_r;
   assign link.systemStartNotice = notice_r;

endmodule : mpors_device

// ==== rtl/mpors_host.sv ====
// Host end: supply gating, switch-on pulse, emergency restart and shutdown
`timescale 1ns/100ps
module mpors_host #(
   parameter int SUPPLY_TO_ON_CYC = mpors_pkg::SUPPLY_TO_ON_CYC,
   parameter int EMERG_HOLD_CYC = mpors_pkg::EMERG_HOLD_CYC,
   parameter int NO_RESPONSE_CYC = mpors_pkg::NO_RESPONSE_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   mpors_if.host link,
   input wire logic powerReq,
   input wire logic resetCmdReq,
   output mpors_pkg::mpors_host_state_t hostState,
   output logic moduleReady
);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   mpors_pkg::mpors_host_state_t state_r;
   mpors_pkg::mpors_host_state_t state_nxt;
   logic [mpors_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic cmdValidNxt, linesLow;
   logic [mpors_pkg::CMD_W-1:0] cmdCodeNxt;

   // readiness seen on the handshake lines
   assign linesLow = link.coreRailIndicator && !link.portAClearToSend &&
      !link.portASetReady && !link.portARingIndicator && !link.portBClearToSend;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 1'b1;
      cmdValidNxt = 1'b0;
      cmdCodeNxt = mpors_pkg::CMD_NONE;
      case (state_r)
         mpors_pkg::HST_OFF: begin
            cnt_nxt = '0;
            if (powerReq) begin
               state_nxt = mpors_pkg::HST_SETTLE;
            end
         end
         mpors_pkg::HST_SETTLE: begin
            if (cnt_r >= mpors_pkg::CNT_W'(SUPPLY_TO_ON_CYC - 1)) begin
               state_nxt = mpors_pkg::HST_PULSE;
               cnt_nxt = '0;
            end
         end
         mpors_pkg::HST_PULSE: begin
            if (cnt_r >= mpors_pkg::CNT_W'(mpors_pkg::ON_PULSE_CYC - 1)) begin
               state_nxt = mpors_pkg::HST_WAIT_START;
               cnt_nxt = '0;
            end
         end
         mpors_pkg::HST_WAIT_START: begin
            if (link.systemStartNotice) begin
               state_nxt = mpors_pkg::HST_READY;
               cnt_nxt = '0;
            end else if (cnt_r >= mpors_pkg::CNT_W'(NO_RESPONSE_CYC - 1)) begin
               // emergency restart only after long silence
               state_nxt = mpors_pkg::HST_EMERG;
               cnt_nxt = '0;
            end
         end
         mpors_pkg::HST_READY: begin
            cnt_nxt = '0;
            if (!powerReq) begin
               state_nxt = mpors_pkg::HST_WAIT_RAIL;
               cmdValidNxt = 1'b1;
               cmdCodeNxt = mpors_pkg::CMD_SWITCH_OFF;
            end else if (resetCmdReq) begin
               state_nxt = mpors_pkg::HST_WAIT_START;
               cmdValidNxt = 1'b1;
               cmdCodeNxt = mpors_pkg::CMD_FUNC_RESET;
            end
         end
         mpors_pkg::HST_EMERG: begin
            // hold the restart line past the threshold
            if (cnt_r >= mpors_pkg::CNT_W'(EMERG_HOLD_CYC - 1)) begin
               state_nxt = mpors_pkg::HST_WAIT_START;
               cnt_nxt = '0;
            end
         end
         mpors_pkg::HST_WAIT_RAIL: begin
            cnt_nxt = '0;
            // silent; supply kept until rail low
            if (!link.coreRailIndicator) begin
               state_nxt = mpors_pkg::HST_OFF;
            end
         end
         default: begin
            state_nxt = mpors_pkg::HST_OFF;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= mpors_pkg::HST_OFF;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers, all registered except restartOut, which is tied low
   // ------------------------------------------------------------
   logic supply_r, switchOn_r, restartOe_r, cmdValid_r;
   logic [mpors_pkg::CMD_W-1:0] cmdCode_r;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         supply_r <= 1'b0;
         switchOn_r <= 1'b0;
         restartOe_r <= 1'b0;
         cmdValid_r <= 1'b0;
         cmdCode_r <= mpors_pkg::CMD_NONE;
         hostState <= mpors_pkg::HST_OFF;
         moduleReady <= 1'b0;
      end else begin
         supply_r <= (state_nxt != mpors_pkg::HST_OFF);
         switchOn_r <= (state_nxt == mpors_pkg::HST_PULSE);
         restartOe_r <= (state_nxt == mpors_pkg::HST_EMERG);
         cmdValid_r <= cmdValidNxt;
         cmdCode_r <= cmdCodeNxt;
         hostState <= state_nxt;
         moduleReady <= (state_nxt == mpors_pkg::HST_READY) && linesLow;
      end
   end

   assign link.mainSupply = supply_r;
   assign link.switchOn = switchOn_r;
   // Open drain: only ever pulls low
   assign link.restartOut = 1'b0;
   assign link.restartOe = restartOe_r;
   assign link.cmdValid = cmdValid_r;
   assign link.cmdCode = cmdCode_r;

endmodule : mpors_host

// ==== testbench/mpors_properties.sv ====
// Pin level properties of the link between host and module ends
`timescale 1ns/100ps
module mpors_properties #(
   parameter int SUPPLY_TO_ON_CYC = mpors_pkg::SUPPLY_TO_ON_CYC,
   parameter int SHUTDOWN_CYC = mpors_pkg::SHUTDOWN_CYC_DEF
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mainSupply,
   input wire logic switchOn,
   input wire logic emergencyRestartN,
   input wire logic coreRailIndicator,
   input wire logic portAClearToSend,
   input wire logic portASetReady,
   input wire logic portARingIndicator,
   input wire logic portBClearToSend,
   input wire logic cmdValid,
   input wire logic [mpors_pkg::CMD_W-1:0] cmdCode,
   input wire logic systemStartNotice
);
   localparam int SD_LO = SHUTDOWN_CYC - 1;
   localparam int SD_HI = SHUTDOWN_CYC + 3;
   logic [31:0] supCnt_r, supCnt_nxt;
   logic offSent_r, offSent_nxt;

   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   always_comb begin
      supCnt_nxt = mainSupply ? supCnt_r + 32'h1 : 32'h0;
      offSent_nxt = offSent_r;
      if (systemStartNotice) begin
         offSent_nxt = 1'b0;
      end else if (cmdValid && cmdCode == mpors_pkg::CMD_SWITCH_OFF) begin
         offSent_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         supCnt_r <= 32'h0;
         offSent_r <= 1'b0;
      end else begin
         supCnt_r <= supCnt_nxt;
         offSent_r <= offSent_nxt;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence startSeq;
      ##[1:8] coreRailIndicator;
   endsequence
   sequence dwellSeq;
      (portAClearToSend && !systemStartNotice) [*8];
   endsequence
   sequence shutdownSeq;
      coreRailIndicator ##[SD_LO:SD_HI] !coreRailIndicator;
   endsequence

   lines_agree_a: assert property (
      portAClearToSend == portASetReady && portAClearToSend == portARingIndicator
      && portAClearToSend == portBClearToSend) else $error("ready lines differ");
   notice_lines_low_a: assert property (
      systemStartNotice |-> !portAClearToSend && coreRailIndicator) else $error("notice, lines up");
   lines_fall_notice_a: assert property (
      $fell(portAClearToSend) && coreRailIndicator |-> systemStartNotice) else $error("no notice");
   notice_pulse_a: assert property (
      systemStartNotice |=> !systemStartNotice) else $error("notice too long");
   start_on_edge_a: assert property (
      $rose(switchOn) && mainSupply && !coreRailIndicator |-> startSeq) else $error("no start");
   reset_dwell_a: assert property (
      $rose(coreRailIndicator) |-> dwellSeq) else $error("reset cut short");
   supply_delay_a: assert property (
      $rose(switchOn) |-> mainSupply && supCnt_r >= SUPPLY_TO_ON_CYC - 1)
      else $error("switch-on too soon");
   shutdown_seq_a: assert property (
      cmdValid && cmdCode == mpors_pkg::CMD_SWITCH_OFF && coreRailIndicator |=> shutdownSeq)
      else $error("no power down");
   rail_before_cut_a: assert property (
      $fell(mainSupply) |-> !$past(coreRailIndicator)) else $error("supply cut, rail up");
   cmd_after_off_a: assert property (
      cmdValid |-> !offSent_r) else $error("command after off");
   on_released_a: assert property (
      systemStartNotice |-> !switchOn) else $error("switch-on still high");
endmodule : mpors_properties

// ==== testbench/testbench.sv ====
// Self-checking bench for the host and module sequencing ends
`timescale 1ns/100ps
module testbench;
   localparam int INIT_CYC = 5, SHUT_CYC = 5, EMERG_CYC = 20, SETTLE_CYC = 30;
   logic clock, arst_n, powerReq, resetCmdReq, moduleReady, sawPdown;
   mpors_pkg::mpors_host_state_t hostState;
   mpors_pkg::mpors_dev_state_t devState, devState2, lastState2;
   logic [mpors_pkg::PAD_W-1:0] padMode, padMode2;
   logic pullDown, pullDown2, gpioIn, gpioIn2, rtc, rtc2;
   int errCount, cmpCount, notices, notices2;
   logic [7:0] lfsr;
   mpors_pkg::mpors_dev_state_t expStates[$], gotStates[$];
   mpors_if lnk();
   mpors_if lnk2();

   mpors_host #(.SUPPLY_TO_ON_CYC(SETTLE_CYC), .EMERG_HOLD_CYC(30), .NO_RESPONSE_CYC(200))
   mpors_host_i (.clock(clock), .arst_n(arst_n), .link(lnk.host), .powerReq(powerReq),
      .resetCmdReq(resetCmdReq), .hostState(hostState), .moduleReady(moduleReady));
   mpors_device #(.EMERG_LOW_CYC(EMERG_CYC), .INIT_CYC(INIT_CYC), .SHUTDOWN_CYC(SHUT_CYC))
   mpors_device_i (.clock(clock), .arst_n(arst_n), .link(lnk.dev), .deviceState(devState),
      .padMode(padMode), .gpioPullDown(pullDown), .gpioInput(gpioIn), .rtcActive(rtc));
   // Bench-driven module end for faults
   generate begin : faultSide
      mpors_device #(.EMERG_LOW_CYC(EMERG_CYC), .INIT_CYC(INIT_CYC), .SHUTDOWN_CYC(SHUT_CYC))
      mpors_device_i (.clock(clock), .arst_n(arst_n), .link(lnk2.dev), .deviceState(devState2),
         .padMode(padMode2), .gpioPullDown(pullDown2), .gpioInput(gpioIn2), .rtcActive(rtc2));
   end endgenerate
   mpors_properties #(.SUPPLY_TO_ON_CYC(SETTLE_CYC), .SHUTDOWN_CYC(SHUT_CYC))
   mpors_properties_i (.clock(clock), .arst_n(arst_n), .mainSupply(lnk.mainSupply),
      .switchOn(lnk.switchOn), .emergencyRestartN(lnk.emergencyRestartN),
      .coreRailIndicator(lnk.coreRailIndicator), .portAClearToSend(lnk.portAClearToSend),
      .portASetReady(lnk.portASetReady), .portARingIndicator(lnk.portARingIndicator),
      .portBClearToSend(lnk.portBClearToSend), .cmdValid(lnk.cmdValid),
      .cmdCode(lnk.cmdCode), .systemStartNotice(lnk.systemStartNotice));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] nextRand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nextRand

   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : giveVerdict

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask : tick

   task automatic chkBit(input string name, input logic exp, input logic got);
      chkVec(name, {7'h0, exp}, {7'h0, got});
   endtask : chkBit

   task automatic chkVec(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmpCount++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chkVec

   task automatic waitDev2(input mpors_pkg::mpors_dev_state_t target, input int bound);
      for (int i = 0; i < bound && devState2 !== target; i++) tick(1);
      chkVec("module state", target, devState2);
      if (devState2 !== target) giveVerdict();
   endtask : waitDev2

   task automatic waitHost(input mpors_pkg::mpors_host_state_t target, input int bound);
      for (int i = 0; i < bound && hostState !== target; i++) tick(1);
      chkVec("host state", target, hostState);
      if (hostState !== target) giveVerdict();
   endtask : waitHost

   task automatic pads2(input logic [1:0] mode, input logic readyHigh);
      chkVec("pad mode", mode, padMode2);
      chkBit("gpio pull down", mode != mpors_pkg::PAD_OFF, pullDown2);
      chkBit("gpio input", mode == mpors_pkg::PAD_FIRMWARE, gpioIn2);
      chkVec("ready lines", {4{readyHigh}}, {lnk2.portAClearToSend, lnk2.portASetReady,
         lnk2.portARingIndicator, lnk2.portBClearToSend});
   endtask : pads2

   task automatic pulseOn2();
      lnk2.switchOn = 1'b1;
      tick(mpors_pkg::ON_PULSE_CYC);
      lnk2.switchOn = 1'b0;
   endtask : pulseOn2

   task automatic cmd2(input logic [1:0] code);
      lnk2.cmdValid = 1'b1;
      lnk2.cmdCode = code;
      tick(1);
      lnk2.cmdValid = 1'b0;
   endtask : cmd2

   task automatic want(input mpors_pkg::mpors_dev_state_t s);
      expStates.push_back(s);
   endtask : want

   // ------------------------------------------------------------
   // Monitors
   // ------------------------------------------------------------
   always @(posedge clock) begin
      if (lnk.systemStartNotice === 1'b1) notices++;
      if (lnk2.systemStartNotice === 1'b1) notices2++;
      if (arst_n === 1'b1 && devState2 !== lastState2) gotStates.push_back(devState2);
      lastState2 = devState2;
      if (devState === mpors_pkg::DEV_PDOWN) begin
         sawPdown = 1'b1;
         chkBit("clock kept", 1'b1, rtc);
         chkBit("rail off", 1'b0, lnk.coreRailIndicator);
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      powerReq = 1'b0;
      resetCmdReq = 1'b0;
      lnk2.mainSupply = 1'b0;
      lnk2.switchOn = 1'b0;
      lnk2.restartOut = 1'b0;
      lnk2.restartOe = 1'b0;
      lnk2.cmdValid = 1'b0;
      lnk2.cmdCode = mpors_pkg::CMD_NONE;
      errCount = 0;
      cmpCount = 0;
      notices = 0;
      notices2 = 0;
      sawPdown = 1'b0;
      lastState2 = mpors_pkg::DEV_OFF;
      lfsr = 8'h58;
      tick(10);
      arst_n = 1'b1;
      powerReq = 1'b1;
      waitHost(mpors_pkg::HST_READY, 400);
      chkVec("module state", mpors_pkg::DEV_RUN, devState);
      chkBit("module ready", 1'b1, moduleReady);
      chkVec("pad mode", mpors_pkg::PAD_FIRMWARE, padMode);
      chkBit("gpio pull down", 1'b1, pullDown);
      chkBit("gpio input", 1'b1, gpioIn);
      resetCmdReq = 1'b1;
      tick(1);
      resetCmdReq = 1'b0;
      tick(3);
      // Bound under host timeout: real restart only
      waitHost(mpors_pkg::HST_READY, 100);
      chkVec("notices", 8'h2, notices[7:0]);
      powerReq = 1'b0;
      waitHost(mpors_pkg::HST_OFF, 100);
      tick(2);
      chkBit("supply", 1'b0, lnk.mainSupply);
      chkBit("power down seen", 1'b1, sawPdown);
      lfsr = nextRand(lfsr);
      tick(int'(lfsr[3:0]) + 1);
      powerReq = 1'b1;
      waitHost(mpors_pkg::HST_READY, 400);
      // Fault side: bench plays the host
      lnk2.mainSupply = 1'b1;
      want(mpors_pkg::DEV_IDLE);
      tick(SETTLE_CYC);
      pulseOn2();
      waitDev2(mpors_pkg::DEV_RUN, 40);
      pads2(mpors_pkg::PAD_FIRMWARE, 1'b0);
      pulseOn2();
      tick(20);
      chkVec("edge in run", mpors_pkg::DEV_RUN, devState2);
      lfsr = nextRand(lfsr);
      lnk2.restartOe = 1'b1;
      tick(int'(lfsr[3:0]) + 1);
      lnk2.restartOe = 1'b0;
      tick(10);
      chkVec("short restart", mpors_pkg::DEV_RUN, devState2);
      lnk2.restartOe = 1'b1;
      tick(EMERG_CYC + 6);
      chkVec("long restart", mpors_pkg::DEV_HELD, devState2);
      pads2(mpors_pkg::PAD_RESET, 1'b1);
      lnk2.restartOe = 1'b0;
      waitDev2(mpors_pkg::DEV_RESET, 8);
      waitDev2(mpors_pkg::DEV_RUN, 40);
      cmd2(mpors_pkg::CMD_FUNC_RESET);
      waitDev2(mpors_pkg::DEV_RESET, 8);
      waitDev2(mpors_pkg::DEV_RUN, 40);
      cmd2(mpors_pkg::CMD_SWITCH_OFF);
      waitDev2(mpors_pkg::DEV_PDOWN, SHUT_CYC + 8);
      chkBit("clock kept", 1'b1, rtc2);
      pads2(mpors_pkg::PAD_OFF, 1'b0);
      cmd2(mpors_pkg::CMD_FUNC_RESET);
      tick(10);
      chkVec("command in power down", mpors_pkg::DEV_PDOWN, devState2);
      pulseOn2();
      waitDev2(mpors_pkg::DEV_RUN, 40);
      lnk2.mainSupply = 1'b0;
      tick(3);
      chkVec("supply removed", mpors_pkg::DEV_OFF, devState2);
      chkBit("clock off", 1'b0, rtc2);
      chkVec("notices", 8'h4, notices2[7:0]);
      for (int k = 0; k < 4; k++) begin
         if (k == 1) want(mpors_pkg::DEV_HELD);
         if (k == 3) begin
            want(mpors_pkg::DEV_SHUTDN);
            want(mpors_pkg::DEV_PDOWN);
         end
         want(mpors_pkg::DEV_RESET);
         want(mpors_pkg::DEV_INIT);
         want(mpors_pkg::DEV_RUN);
      end
      want(mpors_pkg::DEV_OFF);
      chkVec("state count", 8'(expStates.size()), 8'(gotStates.size()));
      foreach (expStates[i]) begin
         if (i < gotStates.size()) chkVec("state order", expStates[i], gotStates[i]);
      end
      giveVerdict();
   end
endmodule : testbench
